//--- verilog/fspc_consts.svh
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef FSPC_CONSTS_SVH
`define FSPC_CONSTS_SVH

// Control/status register addresses
`define FSPC_CSR_DATA_OFS 8'h57
`define FSPC_IO_SHIFT 8'h20
`define FSPC_CSR_IO_OFS 8'h37
`define FSPC_CSR_RESET 8'h00

// Control/status bit positions
`define FSPC_BIT_IE 7
`define FSPC_BIT_BUSY 6
`define FSPC_BIT_SIG 5
`define FSPC_BIT_RWWRE 4

// Legal command combinations of the five low bits
`define FSPC_CMD_RWWRE 5'h11
`define FSPC_CMD_LOCK 5'h09
`define FSPC_CMD_WRITE 5'h05
`define FSPC_CMD_ERASE 5'h03
`define FSPC_CMD_LOAD 5'h01

// Command windows in core cycles
`define FSPC_SPM_WIN 3'h4
`define FSPC_LPM_MIN_LEFT 3'h2

// Programming time, rounded up from the minimum
`define FSPC_CLK_PERIOD_NS 40
`define FSPC_PROG_MIN_NS 3200000
`define FSPC_PROG_MAX_NS 3400000
`define FSPC_PROG_CYC \
    ((`FSPC_PROG_MIN_NS + `FSPC_CLK_PERIOD_NS - 1) / `FSPC_CLK_PERIOD_NS)

// Boot section start word addresses by fuse value
`define FSPC_BOOT_256 14'h3f00
`define FSPC_BOOT_512 14'h3e00
`define FSPC_BOOT_1K 14'h3c00
`define FSPC_BOOT_2K 14'h3800

// Section split
`define FSPC_RWW_END 14'h37ff
`define FSPC_STALLED_READ_SECTION_START 14'h3800
`define FSPC_STALLED_READ_SECTION_FIRST_PAGE 7'h70

// Pointer fields
`define FSPC_Z_PAGE_HI 12
`define FSPC_Z_PAGE_LO 6
`define FSPC_Z_WORD_HI 5
`define FSPC_Z_WORD_LO 1

// Lock and fuse read selects on the pointer low bits
`define FSPC_LOCK_RESET 8'hff
`define FSPC_ZSEL_FUSE_LO 2'h0
`define FSPC_ZSEL_LOCK 2'h1
`define FSPC_ZSEL_FUSE_EXT 2'h2
`define FSPC_ZSEL_FUSE_HI 2'h3

`endif

//--- verilog/fspc_pkg.sv
// Types of the flash self-program sequencer
package fspc_pkg;
    typedef enum logic [1:0] {
        FSPC_IDLE = 2'b00,
        FSPC_ARMED = 2'b01,
        FSPC_BUSY = 2'b11
    } fspc_state_t;

    typedef enum logic [2:0] {
        FSPC_M_LOAD = 3'h0,
        FSPC_M_ERASE = 3'h1,
        FSPC_M_WRITE = 3'h2,
        FSPC_M_LOCK = 3'h3,
        FSPC_M_RWWRE = 3'h4,
        FSPC_M_SIG = 3'h5
    } fspc_mode_t;
endpackage : fspc_pkg

//--- verilog/fspc_prog_timer.sv
// Programming-time counter for erase, write and lock operations
`include "fspc_consts.svh"

module fspc_prog_timer #(
    parameter int unsigned CYCLES = `FSPC_PROG_CYC
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);
    logic [16:0] cnt_r;

    // Load on start, count down to zero
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= 17'h00000;
        end else if (start_i) begin
            cnt_r <= 17'(CYCLES);
        end else if (cnt_r != 17'h00000) begin
            cnt_r <= cnt_r - 17'h00001;
        end
    end

    // Done is the last busy cycle
    assign busy_o = (cnt_r != 17'h00000);
    assign done_o = (cnt_r == 17'h00001);

    property p_prog_time;
        @(posedge clk_i) disable iff (!rstn_i)
        start_i |=> (cnt_r == 17'(CYCLES)) && busy_o;
    endproperty
    a_prog_time: assert property (p_prog_time)
        else $error("programming timer not loaded with full time");
endmodule : fspc_prog_timer

//--- verilog/fspc_top.sv
// Flash self-program control/status logic facing the processor core
`include "fspc_consts.svh"

module fspc_top #(
    parameter int unsigned PROG_CYCLES = `FSPC_PROG_CYC
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic io_space_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    input wire logic spm_i,
    input wire logic lpm_i,
    input wire logic [15:0] zptr_i,
    input wire logic [7:0] low_data_i,
    input wire logic [7:0] high_data_i,
    input wire logic gie_i,
    input wire logic [1:0] boot_size_fuse_i,
    input wire logic [7:0] fuse_low_i,
    input wire logic [7:0] fuse_high_i,
    input wire logic [7:0] fuse_ext_i,
    input wire logic [7:0] sig_data_i,
    output logic ready_irq_o,
    output logic cpu_stall_o,
    output logic rww_read_block_o,
    output logic [13:0] boot_start_o,
    output logic buf_load_o,
    output logic [4:0] buf_word_o,
    output logic [15:0] buf_data_o,
    output logic buf_abort_o,
    output logic erase_start_o,
    output logic write_start_o,
    output logic [6:0] page_o,
    output logic [7:0] lock_bits_o,
    output logic lpm_valid_o,
    output logic [7:0] lpm_data_o
);
    fspc_pkg::fspc_state_t state_r;
    fspc_pkg::fspc_mode_t mode_r;
    fspc_pkg::fspc_mode_t mode_nxt;
    logic ie_r;
    logic busy_flag_r;
    logic [5:0] ctrl_r;
    logic [2:0] win_r;
    logic buf_loaded_r;
    logic stalled_read_section_op_r;
    logic [7:0] lock_data_r;
    logic legal;
    logic csr_hit;
    logic accept;
    logic spm_take;
    logic lpm_take;
    logic expire;
    logic op_start;
    logic stalled_read_section_page;
    logic timer_busy;
    logic timer_done;
    logic [6:0] page_sel;

    // Both address spaces reach the one register
    assign csr_hit = io_space_i ? (addr_i == `FSPC_CSR_IO_OFS)
                                : (addr_i == `FSPC_CSR_DATA_OFS);

    // Command decode; signature needs the enable-only pattern
    always_comb begin
        mode_nxt = fspc_pkg::FSPC_M_LOAD;
        legal = 1'b1;
        case (wdata_i[4:0])
            `FSPC_CMD_LOAD: begin
                mode_nxt = wdata_i[`FSPC_BIT_SIG] ? fspc_pkg::FSPC_M_SIG
                                                  : fspc_pkg::FSPC_M_LOAD;
            end
            `FSPC_CMD_ERASE: mode_nxt = fspc_pkg::FSPC_M_ERASE;
            `FSPC_CMD_WRITE: mode_nxt = fspc_pkg::FSPC_M_WRITE;
            `FSPC_CMD_LOCK: mode_nxt = fspc_pkg::FSPC_M_LOCK;
            `FSPC_CMD_RWWRE: mode_nxt = fspc_pkg::FSPC_M_RWWRE;
            default: legal = 1'b0;
        endcase
    end

    // Commands are taken only when idle; a busy flash keeps its bits
    assign accept = wr_en_i && csr_hit && legal
                    && (state_r == fspc_pkg::FSPC_IDLE);
    assign spm_take = (state_r == fspc_pkg::FSPC_ARMED) && spm_i
                      && (win_r != 3'h0);
    assign lpm_take = (state_r == fspc_pkg::FSPC_ARMED) && lpm_i
                      && (win_r >= `FSPC_LPM_MIN_LEFT);
    // Bits 15:13 never reach any decode
    assign page_sel = zptr_i[`FSPC_Z_PAGE_HI:`FSPC_Z_PAGE_LO];
    assign stalled_read_section_page = (page_sel >= `FSPC_STALLED_READ_SECTION_FIRST_PAGE);
    assign op_start = spm_take && ((mode_r == fspc_pkg::FSPC_M_ERASE)
                      || (mode_r == fspc_pkg::FSPC_M_WRITE)
                      || (mode_r == fspc_pkg::FSPC_M_LOCK));
    assign expire = (state_r == fspc_pkg::FSPC_ARMED) && (win_r == 3'h1)
                    && !spm_take && !lpm_take;

    // Sequencer: a store in signature mode is swallowed
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= fspc_pkg::FSPC_IDLE;
        end else begin
            case (state_r)
                fspc_pkg::FSPC_IDLE: begin
                    if (accept) begin
                        state_r <= fspc_pkg::FSPC_ARMED;
                    end
                end
                fspc_pkg::FSPC_ARMED: begin
                    if (op_start) begin
                        state_r <= fspc_pkg::FSPC_BUSY;
                    end else if (spm_take
                                 && (mode_r != fspc_pkg::FSPC_M_SIG)) begin
                        state_r <= fspc_pkg::FSPC_IDLE;
                    end else if (lpm_take
                                 && ((mode_r == fspc_pkg::FSPC_M_SIG)
                                 || (mode_r == fspc_pkg::FSPC_M_LOCK))) begin
                        state_r <= fspc_pkg::FSPC_IDLE;
                    end else if (expire) begin
                        state_r <= fspc_pkg::FSPC_IDLE;
                    end
                end
                fspc_pkg::FSPC_BUSY: begin
                    if (timer_done) begin
                        state_r <= fspc_pkg::FSPC_IDLE;
                    end
                end
                default: state_r <= fspc_pkg::FSPC_IDLE;
            endcase
        end
    end

    // Mode and window counter from the write cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_r <= fspc_pkg::FSPC_M_LOAD;
            win_r <= 3'h0;
        end else if (accept) begin
            mode_r <= mode_nxt;
            win_r <= `FSPC_SPM_WIN;
        end else if (win_r != 3'h0) begin
            win_r <= win_r - 3'h1;
        end
    end

    // Command bits; enable stays up through a timed operation
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r <= 6'h00;
        end else if (accept) begin
            ctrl_r <= {(wdata_i[`FSPC_BIT_SIG]
                        && (wdata_i[4:0] == `FSPC_CMD_LOAD)), wdata_i[4:0]};
        end else if (timer_done || expire) begin
            ctrl_r <= 6'h00;
        end else if ((state_r == fspc_pkg::FSPC_ARMED) && !op_start
                     && ((spm_take && (mode_r != fspc_pkg::FSPC_M_SIG))
                     || (lpm_take && ((mode_r == fspc_pkg::FSPC_M_SIG)
                     || (mode_r == fspc_pkg::FSPC_M_LOCK))))) begin
            ctrl_r <= 6'h00;
        end
    end

    // Interrupt enable writes are taken at any time
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ie_r <= 1'b0;
        end else if (wr_en_i && csr_hit) begin
            ie_r <= wdata_i[`FSPC_BIT_IE];
        end
    end

    // Section busy: set by a concurrent-section erase or write, cleared only by a re-enable or buffer-load store
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_flag_r <= 1'b0;
        end else if (op_start && !stalled_read_section_page
                     && (mode_r != fspc_pkg::FSPC_M_LOCK)) begin
            busy_flag_r <= 1'b1;
        end else if (spm_take && ((mode_r == fspc_pkg::FSPC_M_RWWRE)
                     || (mode_r == fspc_pkg::FSPC_M_LOAD))) begin
            busy_flag_r <= 1'b0;
        end
    end

    // Buffer fill tracking; a new load beats an abort in the same cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            buf_loaded_r <= 1'b0;
            buf_abort_o <= 1'b0;
        end else begin
            buf_abort_o <= wr_en_i && csr_hit && buf_loaded_r
                           && wdata_i[`FSPC_BIT_RWWRE];
            if (spm_take && (mode_r == fspc_pkg::FSPC_M_LOAD)) begin
                buf_loaded_r <= 1'b1;
            end else if ((wr_en_i && csr_hit && wdata_i[`FSPC_BIT_RWWRE])
                         || (op_start
                         && (mode_r == fspc_pkg::FSPC_M_WRITE))) begin
                buf_loaded_r <= 1'b0;
            end
        end
    end

    // Strobes towards the flash array; data registers ignored for erase and write, lock takes the low byte, a buffer load both bytes
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            buf_load_o <= 1'b0;
            buf_word_o <= 5'h00;
            buf_data_o <= 16'h0000;
            erase_start_o <= 1'b0;
            write_start_o <= 1'b0;
            page_o <= 7'h00;
            stalled_read_section_op_r <= 1'b0;
            lock_data_r <= `FSPC_LOCK_RESET;
        end else begin
            buf_load_o <= spm_take && (mode_r == fspc_pkg::FSPC_M_LOAD);
            erase_start_o <= op_start
                             && (mode_r == fspc_pkg::FSPC_M_ERASE);
            write_start_o <= op_start
                             && (mode_r == fspc_pkg::FSPC_M_WRITE);
            if (spm_take && (mode_r == fspc_pkg::FSPC_M_LOAD)) begin
                buf_word_o <= zptr_i[`FSPC_Z_WORD_HI:`FSPC_Z_WORD_LO];
                buf_data_o <= {high_data_i, low_data_i};
            end
            if (op_start) begin
                page_o <= page_sel;
                stalled_read_section_op_r <= stalled_read_section_page
                             && (mode_r != fspc_pkg::FSPC_M_LOCK);
                lock_data_r <= low_data_i;
            end
        end
    end

    // Lock bits program to zero when the lock write finishes
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lock_bits_o <= `FSPC_LOCK_RESET;
        end else if (timer_done && (mode_r == fspc_pkg::FSPC_M_LOCK)) begin
            lock_bits_o <= lock_bits_o & lock_data_r;
        end
    end

    // Special load results; pointer bits 1:0 pick the lock or fuse byte
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lpm_valid_o <= 1'b0;
            lpm_data_o <= 8'h00;
        end else begin
            lpm_valid_o <= lpm_take && ((mode_r == fspc_pkg::FSPC_M_SIG)
                           || (mode_r == fspc_pkg::FSPC_M_LOCK));
            if (lpm_take && (mode_r == fspc_pkg::FSPC_M_SIG)) begin
                lpm_data_o <= sig_data_i;
            end else if (lpm_take && (mode_r == fspc_pkg::FSPC_M_LOCK)) begin
                case (zptr_i[1:0])
                    `FSPC_ZSEL_LOCK: lpm_data_o <= lock_bits_o;
                    `FSPC_ZSEL_FUSE_HI: lpm_data_o <= fuse_high_i;
                    `FSPC_ZSEL_FUSE_EXT: lpm_data_o <= fuse_ext_i;
                    default: lpm_data_o <= fuse_low_i;
                endcase
            end
        end
    end

    // Register read and boot start decode, both from flops
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= `FSPC_CSR_RESET;
            boot_start_o <= `FSPC_BOOT_256;
        end else begin
            rdata_o <= (rd_en_i && csr_hit) ? {ie_r, busy_flag_r, ctrl_r}
                                             : 8'h00;
            case (boot_size_fuse_i)
                2'b11: boot_start_o <= `FSPC_BOOT_256;
                2'b10: boot_start_o <= `FSPC_BOOT_512;
                2'b01: boot_start_o <= `FSPC_BOOT_1K;
                default: boot_start_o <= `FSPC_BOOT_2K;
            endcase
        end
    end

    fspc_prog_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .start_i(op_start),
        .busy_o(timer_busy),
        .done_o(timer_done)
    );

    // Stall only while the array is busy in the stalled section
    assign cpu_stall_o = (state_r == fspc_pkg::FSPC_BUSY) && stalled_read_section_op_r
                         && timer_busy;
    assign rww_read_block_o = busy_flag_r;
    assign ready_irq_o = ie_r && gie_i && !ctrl_r[0];

    property p_boot_start;
        @(posedge clk_i) disable iff (!rstn_i)
        ##1 boot_start_o == (($past(boot_size_fuse_i) == 2'b11) ? 14'h3f00
            : ($past(boot_size_fuse_i) == 2'b10) ? 14'h3e00
            : ($past(boot_size_fuse_i) == 2'b01) ? 14'h3c00 : 14'h3800);
    endproperty
    a_boot_start: assert property (p_boot_start)
        else $error("boot start address wrong for fuse");

    property p_io_read;
        @(posedge clk_i) disable iff (!rstn_i)
        (rd_en_i && io_space_i && addr_i == 8'h37)
        |=> rdata_o == {$past(ie_r), $past(busy_flag_r), $past(ctrl_r)};
    endproperty
    a_io_read: assert property (p_io_read)
        else $error("register not readable at I/O address");

    property p_load_word;
        @(posedge clk_i) disable iff (!rstn_i)
        (spm_take && mode_r == fspc_pkg::FSPC_M_LOAD) |=> buf_load_o
        && buf_word_o == $past(zptr_i[5:1])
        && buf_data_o == {$past(high_data_i), $past(low_data_i)};
    endproperty
    a_load_word: assert property (p_load_word)
        else $error("page buffer load word or data wrong");

    property p_rww_busy;
        @(posedge clk_i) disable iff (!rstn_i)
        (op_start && mode_r == fspc_pkg::FSPC_M_ERASE && zptr_i[12:6] < 7'h70)
        |=> busy_flag_r && rww_read_block_o && erase_start_o;
    endproperty
    a_rww_busy: assert property (p_rww_busy)
        else $error("section busy not set by concurrent erase");

    property p_stall;
        @(posedge clk_i) disable iff (!rstn_i)
        (op_start && mode_r == fspc_pkg::FSPC_M_WRITE && zptr_i[12:6] >= 7'h70)
        |=> cpu_stall_o [*8];
    endproperty
    a_stall: assert property (p_stall)
        else $error("core not stalled during stalled-section write");

    property p_expire;
        @(posedge clk_i) disable iff (!rstn_i)
        accept ##1 (!spm_i && !lpm_i) [*4] |=> ctrl_r == 6'h00
        && state_r == fspc_pkg::FSPC_IDLE;
    endproperty
    a_expire: assert property (p_expire)
        else $error("command bits not cleared after window");

    property p_enable_held;
        @(posedge clk_i) disable iff (!rstn_i)
        op_start |=> (ctrl_r[0] && !ready_irq_o) [*8];
    endproperty
    a_enable_held: assert property (p_enable_held)
        else $error("enable bit dropped during operation");

    property p_illegal;
        @(posedge clk_i) disable iff (!rstn_i)
        (wr_en_i && csr_hit && !legal && state_r == fspc_pkg::FSPC_IDLE)
        |=> $stable(ctrl_r) && state_r == fspc_pkg::FSPC_IDLE;
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("undefined command combination had an effect");

    property p_abort;
        @(posedge clk_i) disable iff (!rstn_i)
        (wr_en_i && csr_hit && wdata_i[4] && buf_loaded_r)
        |=> buf_abort_o;
    endproperty
    a_abort: assert property (p_abort)
        else $error("buffer load not aborted by read-enable write");

    property p_irq;
        @(posedge clk_i) disable iff (!rstn_i)
        (state_r == fspc_pkg::FSPC_BUSY) |-> !ready_irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("ready interrupt raised while flash busy");
endmodule : fspc_top

//--- tb/fspc_core_model.sv
// Core-side partner: signature row and fuse bytes seen by the sequencer
module fspc_core_model #(
    parameter logic [7:0] SIG_SEED = 8'h5a // Arbitrary value, no real part
) (
    input wire logic [15:0] zptr_i,
    output logic [7:0] sig_data_o,
    output logic [7:0] fuse_low_o,
    output logic [7:0] fuse_high_o,
    output logic [7:0] fuse_ext_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Byte moves with the pointer, so a stale lookup shows up
    assign sig_data_o = SIG_SEED ^ zptr_i[7:0];
    // Distinct fuse bytes so a wrong select cannot pass
    assign fuse_low_o = 8'h62;
    assign fuse_high_o = 8'hd9;
    assign fuse_ext_o = 8'hfd;
endmodule : fspc_core_model

//--- tb/tb.sv
// Self-checking bench of the flash self-program sequencer
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PC = 20;
    logic clk_i = 0, rstn_i = 0, wr_en_i = 0, rd_en_i = 0, io_space_i = 0;
    logic spm_i = 0, lpm_i = 0, gie_i = 0, rd_d = 0;
    logic [7:0] addr_i = 0, wdata_i = 0, low_data_i = 0, high_data_i = 0;
    logic [15:0] zptr_i = 0;
    logic [1:0] boot_size_fuse_i = 2'h3;
    wire [7:0] fuse_low_i, fuse_high_i, fuse_ext_i, sig_data_i;
    logic [7:0] rdata_o, lock_bits_o, lpm_data_o, lk;
    logic ready_irq_o, cpu_stall_o, rww_read_block_o, buf_load_o;
    logic buf_abort_o, erase_start_o, write_start_o, lpm_valid_o;
    logic [13:0] boot_start_o;
    logic [4:0] buf_word_o;
    logic [15:0] buf_data_o;
    logic [6:0] page_o;
    logic [13:0] bt[4] = '{14'h3800, 14'h3c00, 14'h3e00, 14'h3f00};
    logic [7:0] fv[4];
    logic [20:0] q_rd[$], q_buf[$], q_lpm[$], q_pg[$];
    logic [31:0] rng = 32'h13;
    int fails = 0, checks_done = 0, ab = 0;

    fspc_top #(.PROG_CYCLES(PC)) DUT (
        .clk_i, .rstn_i, .wr_en_i, .rd_en_i, .io_space_i, .addr_i,
        .wdata_i, .rdata_o, .spm_i, .lpm_i, .zptr_i, .low_data_i,
        .high_data_i, .gie_i, .boot_size_fuse_i, .fuse_low_i,
        .fuse_high_i, .fuse_ext_i, .sig_data_i, .ready_irq_o,
        .cpu_stall_o, .rww_read_block_o, .boot_start_o, .buf_load_o,
        .buf_word_o, .buf_data_o, .buf_abort_o, .erase_start_o,
        .write_start_o, .page_o, .lock_bits_o, .lpm_valid_o, .lpm_data_o
    );
    fspc_core_model core (
        .zptr_i, .sig_data_o(sig_data_i), .fuse_low_o(fuse_low_i),
        .fuse_high_o(fuse_high_i), .fuse_ext_o(fuse_ext_i)
    );

    // Free-running core clock
    initial forever #20 clk_i = ~clk_i;

    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    task automatic chk(string n, logic [20:0] e, logic [20:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // An empty queue means the result was never asked for
    task automatic pop(string n, ref logic [20:0] q[$], input logic [20:0] g);
        chk(n, q.size() ? q.pop_front() : ~g, g);
    endtask : pop

    task automatic summarize;
        if (fails == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize

    task automatic cyc(int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc

    task automatic wr(logic [7:0] a, logic [7:0] d, bit io = 0);
        @(posedge clk_i);
        {wr_en_i, io_space_i, addr_i, wdata_i} <= {1'b1, io, a, d};
        @(posedge clk_i);
        wr_en_i <= 0;
    endtask : wr

    task automatic rd(logic [7:0] a, logic [7:0] e, bit io = 0);
        @(posedge clk_i);
        {rd_en_i, io_space_i, addr_i} <= {1'b1, io, a};
        q_rd.push_back(21'(e));
        @(posedge clk_i);
        rd_en_i <= 0;
    endtask : rd

    // Instruction lands in the first cycle of the window, the earliest case
    task automatic op(logic [7:0] d, bit s, bit l);
        wr(8'h57, d);
        {spm_i, lpm_i} <= {s, l};
        @(posedge clk_i);
        {spm_i, lpm_i} <= 2'b00;
    endtask : op

    // Read data lags its request by one edge
    always @(posedge clk_i) rd_d <= rd_en_i;

    // Results taken mid-cycle, after the edge updates have landed
    always @(negedge clk_i) begin
        if (rd_d) pop("rdata", q_rd, 21'(rdata_o));
        if (buf_load_o)
            pop("buffer", q_buf, {buf_word_o, buf_data_o});
        if (lpm_valid_o) pop("lpm", q_lpm, 21'(lpm_data_o));
        if (erase_start_o | write_start_o)
            pop("page", q_pg, 21'({write_start_o, page_o}));
        if (buf_abort_o) ab--;
    end

    // Watchdog against a hang
    initial begin
        cyc(5000);
        fails++;
        summarize();
    end

    initial begin
        cyc(10);
        rstn_i <= 1;
        rd(8'h57, 8'h00);
        rd(8'h37, 8'h00, 1);
        wr(8'h37, 8'h80, 1);
        rd(8'h57, 8'h80);
        rd(8'h58, 8'h00);
        foreach (bt[i]) begin
            boot_size_fuse_i <= 2'(i);
            cyc(3);
            chk("boot", 21'(bt[i]), 21'(boot_start_o));
        end
        gie_i <= 1;
        cyc(2);
        chk("irq", 21'd1, 21'(ready_irq_o));
        wr(8'h57, 8'h81);
        @(negedge clk_i);
        chk("irq", 21'd0, 21'(ready_irq_o));
        cyc(6);
        rd(8'h57, 8'h80);
        wr(8'h57, 8'h87);
        rd(8'h57, 8'h80);
        // Loads with junk in the ignored pointer bits, byte bit kept low
        repeat (4) begin
            rng = xs(rng);
            zptr_i <= {rng[15:1], 1'b0};
            {high_data_i, low_data_i} <= rng[31:16];
            q_buf.push_back({rng[5:1], rng[31:16]});
            op(8'h01, 1, 0);
        end
        ab = 1;
        wr(8'h57, 8'h10);
        cyc(2);
        chk("abort", 21'd0, 21'(ab));
        // Erase in the concurrent section: busy, no stall
        zptr_i <= 16'h1234;
        q_pg.push_back(21'h048);
        op(8'h03, 1, 0);
        cyc(2);
        chk("busy", 21'd1, 21'(rww_read_block_o));
        chk("stall", 21'd0, 21'(cpu_stall_o));
        rd(8'h57, 8'h43);
        cyc(PC + 6);
        rd(8'h57, 8'h40);
        op(8'h11, 1, 0);
        cyc(2);
        rd(8'h57, 8'h00);
        // Page write in the stalled section, word field zero
        zptr_i <= 16'hffc0;
        q_pg.push_back(21'h0ff);
        // Interrupt enabled here so a ready request during busy would show
        op(8'h85, 1, 0);
        cyc(2);
        chk("stall", 21'd1, 21'(cpu_stall_o));
        chk("busy", 21'd0, 21'(rww_read_block_o));
        chk("irq", 21'd0, 21'(ready_irq_o));
        cyc(PC + 6);
        chk("stall", 21'd0, 21'(cpu_stall_o));
        chk("irq", 21'd1, 21'(ready_irq_o));
        rng = xs(rng);
        low_data_i <= rng[7:0];
        lk = rng[7:0];
        op(8'h09, 1, 0);
        cyc(PC + 6);
        chk("lock", 21'(lk), 21'(lock_bits_o));
        fv = '{fuse_low_i, lk, fuse_ext_i, fuse_high_i};
        for (int z = 0; z < 4; z++) begin
            zptr_i <= 16'(z);
            q_lpm.push_back(21'(fv[z]));
            op(8'h09, 0, 1);
            cyc(6);
        end
        zptr_i <= 16'h0002;
        op(8'h21, 0, 1);
        q_lpm.push_back(21'(sig_data_i));
        cyc(6);
        op(8'h21, 1, 0);
        cyc(6);
        rd(8'h57, 8'h00);
        // Mid-run reset brings back the unprogrammed lock byte
        rstn_i <= 0;
        cyc(2);
        rstn_i <= 1;
        chk("lock", 21'hff, 21'(lock_bits_o));
        rd(8'h57, 8'h00);
        cyc(4);
        chk("left", 21'd0, 21'(q_rd.size() + q_buf.size()
            + q_lpm.size() + q_pg.size()));
        summarize();
    end
endmodule : tb
